/* File: verilog/ahcg_top.sv */
// Header check generator behind the processor register file
//
// Behaviour
// [R1] Mode bit 9 enables generation mode
// [R2] Second operand plain register, resets all ones
// [R3] Generation mode: second operand reads result
// [R4] First operand feeds generator, resets zero
// [R5] Two 16-bit words give one check byte
// [R6] Firmware writes header bytes 1-2, then 3-4
// [R7] First operand write reinitialises the seed
// [R8] Second write completes; result in low byte
// [R9] Firmware waits until fourth instruction after
// [R10] Firmware inserts or compares the check byte
// [R11] Firmware waits two instructions after mode write
// [R12] CRC-8, polynomial x^8+x^2+x+1, ATM coset
`timescale 1ns/10ps
`include "ahcg_map.svh"

module ahcg_top (
	input  wire logic                 clk,
	input  wire logic                 resetn,
	input  wire ahcg_pkg::ahcg_wr_s   reg_wr,
	input  wire ahcg_pkg::ahcg_rd_s   reg_rd,
	output ahcg_pkg::ahcg_word_t      reg_rd_data,
	output logic                      hec_mode,
	output logic                      hec_busy
);

	ahcg_pkg::ahcg_state_s           st_r;
	ahcg_pkg::ahcg_state_s           st_nxt;

	// Register strobes, one per mapped index
	logic                            mode_on;
	logic                            wr_first;
	logic                            wr_second;
	logic                            wr_mode;
	logic                            rd_first;
	logic                            rd_second;
	logic                            rd_mode;

	// Generator datapath
	ahcg_pkg::ahcg_byte_t            seed_crc;
	ahcg_pkg::ahcg_byte_t            close_crc;
	logic                            land_now;
	logic                            busy_nxt;
	wire logic [2:0]                 pipe_v_sh;
	wire ahcg_pkg::ahcg_byte_t [2:0] pipe_crc_sh;
	ahcg_pkg::ahcg_word_t            rd_word;

	// [R12] One byte through the CRC-8 divider, MSB first
	function automatic ahcg_pkg::ahcg_byte_t crc_byte(
		input ahcg_pkg::ahcg_byte_t crc_in,
		input ahcg_pkg::ahcg_byte_t data
	);
		ahcg_pkg::ahcg_byte_t c;
		logic                 fb;
		c = crc_in;
		for (int i = 7; i >= 0; i--) begin
			// Feedback is the top bit against data
			fb = c[7] ^ data[i];
			c  = {c[6:0], 1'b0};
			if (fb) begin
				c = c ^ `AHCG_CRC_POLY;
			end
		end
		return c;
	endfunction

	// [R5] Upper byte enters first, header order
	function automatic ahcg_pkg::ahcg_byte_t crc_word(
		input ahcg_pkg::ahcg_byte_t crc_in,
		input ahcg_pkg::ahcg_word_t word
	);
		ahcg_pkg::ahcg_byte_t hi;
		hi = crc_byte(crc_in, word[15:8]);
		return crc_byte(hi, word[7:0]);
	endfunction

	// [R1] Generation mode switch
	assign mode_on = st_r.mode_r[`AHCG_MODE_HEC_BIT];

	// Write strobes; unmapped indices are ignored
	always_comb begin
		wr_first  = 1'b0;
		wr_second = 1'b0;
		wr_mode   = 1'b0;
		if (reg_wr.en) begin
			case (reg_wr.idx)
				`AHCG_IDX_FIRST:  wr_first  = 1'b1;
				`AHCG_IDX_SECOND: wr_second = 1'b1;
				`AHCG_IDX_MODE:   wr_mode   = 1'b1;
				default:          wr_mode   = 1'b0;
			endcase
		end
	end

	// Read strobes; unmapped indices read zero
	always_comb begin
		rd_first  = 1'b0;
		rd_second = 1'b0;
		rd_mode   = 1'b0;
		if (reg_rd.en) begin
			case (reg_rd.idx)
				`AHCG_IDX_FIRST:  rd_first  = 1'b1;
				`AHCG_IDX_SECOND: rd_second = 1'b1;
				`AHCG_IDX_MODE:   rd_mode   = 1'b1;
				default:          rd_mode   = 1'b0;
			endcase
		end
	end

	// [R7] Seed restarts on every first-word write while generation mode is on
	always_comb begin
		seed_crc  = crc_word(`AHCG_CRC_SEED, reg_wr.data);
		// [R5] Second word closes the check byte
		close_crc = crc_word(st_r.mid_crc_r, reg_wr.data)
			^ `AHCG_CRC_COSET;
	end

	// [R8] Result pipeline, one stage per edge
	// Stage 0 is loaded by the second write
	assign pipe_v_sh[0]   = 1'b0;
	assign pipe_crc_sh[0] = 8'h00;
	for (genvar g = 1; g < `AHCG_HEC_LAT; g++) begin
		assign pipe_v_sh[g]   = st_r.pipe_v_r[g-1];
		assign pipe_crc_sh[g] = st_r.pipe_crc_r[g-1];
	end

	// [R8] Byte lands only while mode is still on
	// Clearing mode in flight drops the result
	assign land_now = st_r.pipe_v_r[`AHCG_HEC_LAT-1] && mode_on;

	// [R3] Read mux; a same-cycle write is not seen
	always_comb begin
		// Idle or unmapped reads return zero
		rd_word = 16'h0000;
		if (rd_first) begin
			rd_word = st_r.first_r;
		end
		if (rd_second) begin
			rd_word = st_r.second_r;
		end
		if (rd_mode) begin
			rd_word = st_r.mode_r;
		end
	end

	always_comb begin
		st_nxt = st_r;

		// Result pipeline advances every cycle
		st_nxt.pipe_v_r   = pipe_v_sh;
		st_nxt.pipe_crc_r = pipe_crc_sh;

		// [R8] Result lands in low byte after the delay
		if (land_now) begin
			st_nxt.second_r = {8'h00,
				st_r.pipe_crc_r[`AHCG_HEC_LAT-1]};
		end

		// [R4] First operand plain storage
		if (wr_first) begin
			st_nxt.first_r = reg_wr.data;
			// [R7] Seed reset, then first word absorbed
			if (mode_on) begin
				st_nxt.mid_crc_r = seed_crc;
			end
		end

		// [R2] Second operand plain storage
		// A write in the landing cycle wins
		if (wr_second) begin
			st_nxt.second_r = reg_wr.data;
			// [R5] Second word enters the pipeline
			if (mode_on) begin
				st_nxt.pipe_v_r[0]   = 1'b1;
				st_nxt.pipe_crc_r[0] = close_crc;
			end
		end

		// [R1] Mode register is plain storage
		if (wr_mode) begin
			st_nxt.mode_r = reg_wr.data;
		end

		// Registered read port, one cycle latency
		st_nxt.rd_data_r = rd_word;
	end

	// [R8] Any stage still holding a byte
	assign busy_nxt = |st_nxt.pipe_v_r;

	// State register, constant reset values
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_r.first_r    <= `AHCG_FIRST_RST;
			st_r.second_r   <= `AHCG_SECOND_RST;
			st_r.mode_r     <= `AHCG_MODE_RST;
			st_r.mid_crc_r  <= `AHCG_CRC_SEED;
			st_r.pipe_v_r   <= 3'h0;
			st_r.pipe_crc_r <= 24'h000000;
			st_r.rd_data_r  <= 16'h0000;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Status outputs straight from flip-flops
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			hec_mode <= 1'b0;
			hec_busy <= 1'b0;
		end else begin
			// [R1] Mode flag follows the stored bit
			hec_mode <= st_nxt.mode_r[`AHCG_MODE_HEC_BIT];
			hec_busy <= busy_nxt;
		end
	end

	assign reg_rd_data = st_r.rd_data_r;

endmodule

/* File: verilog/ahcg_map.svh */
// Register indices, field positions, reset values and timing counts
`ifndef AHCG_MAP_SVH
`define AHCG_MAP_SVH

`define AHCG_IDX_FIRST    6'h20
`define AHCG_IDX_SECOND   6'h21
`define AHCG_IDX_MODE     6'h2A
`define AHCG_MODE_HEC_BIT 9
`define AHCG_FIRST_RST    16'h0000
`define AHCG_SECOND_RST   16'hFFFF
`define AHCG_MODE_RST     16'h0000
`define AHCG_CRC_POLY     8'h07
`define AHCG_CRC_SEED     8'h00
`define AHCG_CRC_COSET    8'h55
`define AHCG_HEC_LAT      3

`endif

/* File: verilog/ahcg_pkg.sv */
// Types shared by the header check generator
package ahcg_pkg;

	typedef logic [5:0]  ahcg_idx_t;
	typedef logic [15:0] ahcg_word_t;
	typedef logic [7:0]  ahcg_byte_t;

	typedef struct packed {
		logic       en;
		ahcg_idx_t  idx;
		ahcg_word_t data;
	} ahcg_wr_s;

	typedef struct packed {
		logic      en;
		ahcg_idx_t idx;
	} ahcg_rd_s;

	typedef struct packed {
		ahcg_word_t      first_r;
		ahcg_word_t      second_r;
		ahcg_word_t      mode_r;
		ahcg_byte_t      mid_crc_r;
		logic [2:0]      pipe_v_r;
		ahcg_byte_t [2:0] pipe_crc_r;
		ahcg_word_t      rd_data_r;
	} ahcg_state_s;

endpackage

/* File: tb/ahcg_checker.sv */
// Port-level assertions on the header check generator
`timescale 1ns/10ps
module ahcg_checker (
	input wire logic	clk,
	input wire logic	resetn,
	input wire ahcg_pkg::ahcg_wr_s	reg_wr,
	input wire ahcg_pkg::ahcg_rd_s	reg_rd,
	input wire ahcg_pkg::ahcg_word_t	reg_rd_data,
	input wire logic	hec_mode,
	input wire logic	hec_busy
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	a_mode_bit: assert property (reg_wr.en && reg_wr.idx == 6'h2A |=>
		hec_mode == $past(reg_wr.data[9])) else $error("mode");
	a_busy_start: assert property (hec_mode && reg_wr.en &&
		reg_wr.idx == 6'h21 |=> hec_busy) else $error("busy");
	a_mode_hold: assert property (!(reg_wr.en && reg_wr.idx == 6'h2A)
		|=> $stable(hec_mode)) else $error("mode moved");
	a_busy_idle: assert property (!hec_mode && !hec_busy |=>
		!hec_busy) else $error("busy without mode");
	a_busy_three: assert property ($rose(hec_busy) |->
		hec_busy[*3]) else $error("busy short");
	a_busy_drop: assert property ((hec_mode && reg_wr.en &&
		reg_wr.idx == 6'h21) ##1
		(!(reg_wr.en && reg_wr.idx == 6'h21))[*3]
		|=> !hec_busy) else $error("busy stuck");
endmodule
bind ahcg_top ahcg_checker i_chk (.clk(clk), .resetn(resetn),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data),
	.hec_mode(hec_mode), .hec_busy(hec_busy));

/* File: tb/ahcg_host.sv */
// Host model
`timescale 1ns/10ps
module ahcg_host (
	input wire logic	clk,
	output ahcg_pkg::ahcg_wr_s	reg_wr,
	output ahcg_pkg::ahcg_rd_s	reg_rd
);
	initial {reg_wr, reg_rd} = 30'h0;
	task automatic xfer(input logic w, logic [5:0] i, logic [15:0] d);
		@(posedge clk) #1 reg_wr = '{w, i, d};
		reg_rd = '{!w, i};
		@(posedge clk) #1 {reg_wr, reg_rd} = 30'h0;
	endtask
endmodule

/* File: tb/tb.sv */
// Bench: register port scenarios and closing verdict
`timescale 1ns/10ps
module tb;
	logic	clk = 1'h0;
	logic	resetn = 1'h0;
	ahcg_pkg::ahcg_wr_s	wr;
	ahcg_pkg::ahcg_rd_s	rd;
	ahcg_pkg::ahcg_word_t	q;
	logic	mode;
	logic	busy;
	int	fail_count, n_tests;
	always #2 clk = ~clk;
	ahcg_top i_ahcg_top (.clk(clk), .resetn(resetn), .reg_wr(wr),
		.reg_rd(rd), .reg_rd_data(q), .hec_mode(mode),
		.hec_busy(busy));
	ahcg_host i_ahcg_host (.clk(clk), .reg_wr(wr), .reg_rd(rd));
	task automatic chk(input logic [5:0] i, logic [15:0] e);
		n_tests++;
		i_ahcg_host.xfer(1'h0, i, 16'h0);
		if (q !== e) begin
			fail_count++;
			$display("[ERR] %0t got %h", $time, q);
		end
	endtask
	task automatic flag(input logic got, logic e);
		n_tests++;
		if (got !== e) begin
			fail_count++;
			$display("[ERR] %0t flag %b", $time, got);
		end
	endtask
	task automatic t_reset();
		chk(6'h20, 16'h0000);
		chk(6'h21, 16'hFFFF);
		flag(mode, 1'h0);
		flag(busy, 1'h0);
	endtask
	task automatic t_mode(input logic [15:0] d, logic e);
		i_ahcg_host.xfer(1'h1, 6'h2A, d);
		flag(mode, e);
		repeat (2) @(posedge clk);
	endtask
	task automatic t_hec(input logic [31:0] h, logic [7:0] e);
		i_ahcg_host.xfer(1'h1, 6'h20, h[31:16]);
		i_ahcg_host.xfer(1'h1, 6'h21, h[15:0]);
		flag(busy, 1'h1);
		repeat (2) @(posedge clk);
		chk(6'h21, {8'h00, e});
		flag(busy, 1'h0);
	endtask
	task automatic t_plain();
		i_ahcg_host.xfer(1'h1, 6'h21, 16'h1234);
		chk(6'h21, 16'h1234);
		i_ahcg_host.xfer(1'h1, 6'h20, 16'hA5C3);
		chk(6'h20, 16'hA5C3);
	endtask
	task automatic finish_test();
		$display("n %0d f %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		#1 resetn = 1'h1;
		t_reset();
		t_mode(16'hFDFF, 1'h0);
		t_mode(16'h0200, 1'h1);
		t_hec(32'h00010000, 8'h3E);
		t_hec(32'h00000100, 8'h40);
		t_mode(16'h0000, 1'h0);
		t_plain();
		finish_test();
	end
endmodule
